// ===== rtl/io_mapper_defines.svh
// Purpose: Shared constants of the fieldbus I/O image mapper.
// Assumes: Byte addresses on the register bus, 32-bit data.
// Notes: Definitions only.
`ifndef IO_MAPPER_DEFINES_SVH
`define IO_MAPPER_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define TICK_PERIOD_US 1000
`define TICK_CYCLES ((`TICK_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define EXCH_TIMEOUT_MS 10

`define STD_IO_COUNT 24
`define EXT_IO_COUNT 128
`define STATUS_BYTE_IDX 5'h03

`define REG_CTRL_OFS 6'h00
`define REG_NET_STATUS_OFS 6'h04
`define REG_IRQ_STATUS_OFS 6'h08
`define REG_IRQ_MASK_OFS 6'h0C

`define CTRL_EXTENDED_BIT 0
`define CTRL_NET_ENABLE_BIT 1
`define CTRL_RESET 2'h2

`define NST_RATE_LSB 0
`define NST_CFG_ERROR_BIT 2
`define NST_JOINED_BIT 3
`define NST_ACTIVE_BIT 4
`define NST_ADDR_LSB 8

`define IRQ_EXCH_START_BIT 0
`define IRQ_EXCH_LOST_BIT 1
`define IRQ_CFG_ERROR_BIT 2
`define IRQ_RX_BYTE_BIT 3
`define IRQ_RESET 4'h0
`define IRQ_MASK_RESET 4'h0

`define SB_OUTPUT_FAULT_BIT 0
`define SB_INPUT_FAULT_BIT 1
`define SB_GENERAL_FAULT_BIT 2
`define SB_DIAGNOSTIC_BIT 3
`define SB_RUN_BIT 4
`define SB_EXCHANGE_BIT 5

`endif

// ===== rtl/io_mapper_pkg.sv
// Purpose: Types of the fieldbus I/O image mapper.
// Assumes: Constants live in io_mapper_defines.svh.
// Notes: One-hot start-up states.
package io_mapper_pkg;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_ERROR = 3'b100
  } startup_state_e;

  typedef enum logic [1:0] {
    RATE_125K = 2'h0,
    RATE_250K = 2'h1,
    RATE_500K = 2'h2,
    RATE_BAD = 2'h3
  } bit_rate_select_e;

endpackage

// ===== rtl/pulse_divider.sv
// Purpose: One-cycle enable pulse every CYCLES clocks.
// Assumes: Single clock domain.
// Notes: Tick is registered.
`timescale 1ns/100ps
`default_nettype none
module pulse_divider #(
  parameter int CYCLES = 100000
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("pulse_divider: CYCLES must be at least 1");
  end

  logic [W-1:0] count;
  wire last_count = (count == W'(CYCLES - 1));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count <= '0;
      tick_o <= 1'b0;
    end else begin
      count <= last_count ? '0 : count + W'(1);
      tick_o <= last_count;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/exchange_watchdog.sv
// Purpose: Tracks whether process data is being exchanged.
// Assumes: tick_i is a one-cycle pulse per time unit.
// Notes: Start and lost are registered one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module exchange_watchdog #(
  parameter int TIMEOUT_TICKS = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic activity_i,
  input wire logic tick_i,
  output logic active_o,
  output logic start_o,
  output logic lost_o
);
  localparam int W = $clog2(TIMEOUT_TICKS + 1);

  if (TIMEOUT_TICKS < 2) begin : g_bad_timeout
    $error("exchange_watchdog: TIMEOUT_TICKS must be at least 2");
  end

  logic [W-1:0] idle_ticks;
  // A tick may land just after activity, so the window is TIMEOUT-1 to TIMEOUT ticks
  wire expired = tick_i && (idle_ticks == W'(TIMEOUT_TICKS - 1));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active_o <= 1'b0;
      start_o <= 1'b0;
      lost_o <= 1'b0;
      idle_ticks <= '0;
    end else begin
      start_o <= enable_i && activity_i && !active_o;
      lost_o <= active_o && (!enable_i || (!activity_i && expired));
      if (!enable_i) begin
        active_o <= 1'b0;
        idle_ticks <= '0;
      end else if (activity_i) begin
        active_o <= 1'b1;
        idle_ticks <= '0;
      end else if (active_o && tick_i) begin
        active_o <= !expired;
        idle_ticks <= expired ? '0 : idle_ticks + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/fieldbus_io_image_mapper.sv
// Purpose: Maps base-unit virtual I/O to byte-wide fieldbus process data.
// Assumes: Network byte ports come from a protocol engine on the same clock.
// Notes: Avalon-MM slave answers every request in two cycles.
//
// What this block does
// - Master input bit n lands on base input n
// - Output n sits at byte n/8 bit n%8 up to output 23, at byte n/8+1 bit n%8 from output 24
// - I/O 0..23 occupy bytes 0..2
// - Byte 3 bits 0..4 carry indicator states
// - Byte 3 bit 5 flags active exchange
// - Two switches select 125, 250, 500 kBit/s
// - Six weighted switches give address 0..63
// - Start-up loads configuration, then runs unaided
// - Extended mode maps up to 128 I/O
`timescale 1ns/100ps
`default_nettype none
`include "io_mapper_defines.svh"
module fieldbus_io_image_mapper
  import io_mapper_pkg::*;
#(
  parameter int IO_COUNT = `EXT_IO_COUNT,
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int EXCH_TIMEOUT_TICKS = `EXCH_TIMEOUT_MS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  // Configuration switches
  input wire logic rate_switch_low_i,
  input wire logic rate_switch_high_i,
  input wire logic [5:0] addr_switch_i,
  output logic [1:0] bit_rate_select_o,
  output logic [5:0] station_address_o,
  output logic net_enable_o,
  // Process data from the master
  input wire logic net_in_valid_i,
  input wire logic [4:0] net_in_index_i,
  input wire logic [7:0] net_in_data_i,
  // Process data to the master
  input wire logic net_out_req_i,
  input wire logic [4:0] net_out_index_i,
  output logic [7:0] net_out_data_o,
  output logic net_out_valid_o,
  // Base unit side
  input wire logic [IO_COUNT-1:0] base_outputs_i,
  output logic [IO_COUNT-1:0] base_inputs_o,
  input wire logic output_fault_flag_i,
  input wire logic input_fault_flag_i,
  input wire logic general_fault_flag_i,
  input wire logic diagnostic_flag_i,
  input wire logic run_flag_i,
  // Indicators
  output logic network_state_indicator_o,
  output logic module_state_indicator_o
);

  if (IO_COUNT < `STD_IO_COUNT || IO_COUNT > `EXT_IO_COUNT || (IO_COUNT % 8) != 0) begin : g_bad_io
    $error("fieldbus_io_image_mapper: IO_COUNT must be a multiple of 8 in 24..128");
  end

  // The divider needs one cycle per tick; the watchdog window needs two ticks
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("fieldbus_io_image_mapper: TICK_CYCLES must be at least 1");
  end

  if (EXCH_TIMEOUT_TICKS < 2) begin : g_bad_timeout
    $error("fieldbus_io_image_mapper: EXCH_TIMEOUT_TICKS must be at least 2");
  end

  // Start-up and configuration

  startup_state_e state;
  startup_state_e next_state;
  logic [1:0] rate_latched;
  logic [5:0] addr_latched;
  logic [1:0] ctrl;

  // Switch order: low switch is bit 0, high switch bit 1
  wire [1:0] rate_switches = {rate_switch_high_i, rate_switch_low_i};
  wire rate_invalid = (rate_switches == RATE_BAD);
  wire ext_mode = ctrl[`CTRL_EXTENDED_BIT];
  wire joined = (state == ST_RUN) && ctrl[`CTRL_NET_ENABLE_BIT];
  wire cfg_error = (state == ST_ERROR);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOAD: next_state = rate_invalid ? ST_ERROR : ST_RUN;
      ST_RUN: next_state = ST_RUN;
      ST_ERROR: next_state = ST_ERROR;
      default: next_state = ST_LOAD;
    endcase
  end

  // Switches are read once after reset; later changes need a reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_LOAD;
      rate_latched <= 2'h0;
      addr_latched <= 6'h00;
    end else begin
      state <= next_state;
      if (state == ST_LOAD) begin
        rate_latched <= rate_switches;
        addr_latched <= addr_switch_i;
      end
    end
  end

  assign bit_rate_select_o = rate_latched;
  assign station_address_o = addr_latched;
  assign net_enable_o = joined;

  // Mapping helpers

  // Highest I/O count served in the current mode
  function automatic int io_limit(input logic ext);
    return ext ? IO_COUNT : `STD_IO_COUNT;
  endfunction

  // First I/O number carried by a byte; output bytes above the status byte shift down one
  function automatic int bit_base(input logic [4:0] idx, input logic is_out);
    if (is_out && idx > `STATUS_BYTE_IDX) begin
      return (int'(idx) - 1) * 8;
    end
    return int'(idx) * 8;
  endfunction

  // A byte is served only when all eight of its I/O exist in the current mode
  function automatic logic byte_served(input int base, input logic ext);
    return (base + 8) <= io_limit(ext);
  endfunction

  // Output bytes: 0..2 for o0..o23, 3 is status, 4.. for o24 upward
  function automatic logic [7:0] out_byte(input logic [4:0] idx, input logic ext,
                                          input logic [IO_COUNT-1:0] outs, input logic [7:0] status);
    int base;
    base = bit_base(idx, 1'b1);
    if (idx == `STATUS_BYTE_IDX) begin
      return status;
    end else if (byte_served(base, ext)) begin
      return outs[base +: 8];
    end else begin
      return 8'h00;
    end
  endfunction

  // Process data in

  logic [IO_COUNT-1:0] in_image;
  int in_base;

  // Inputs are linear: byte k carries inputs 8k..8k+7
  assign in_base = bit_base(net_in_index_i, 1'b0);
  wire in_accept = joined && net_in_valid_i && byte_served(in_base, ext_mode);
  wire out_accept = joined && net_out_req_i;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      in_image <= '0;
    end else if (!joined) begin
      in_image <= '0;
    end else if (in_accept) begin
      in_image[in_base +: 8] <= net_in_data_i;
    end
  end

  // Inputs beyond 23 stay clear outside extended mode
  wire [IO_COUNT-1:0] in_mask = ext_mode ? {IO_COUNT{1'b1}} : IO_COUNT'({`STD_IO_COUNT{1'b1}});

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      base_inputs_o <= '0;
    end else begin
      base_inputs_o <= in_image & in_mask;
    end
  end

  // Exchange supervision

  logic tick;
  logic exch_active;
  logic exch_start;
  logic exch_lost;

  pulse_divider #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  exchange_watchdog #(
    .TIMEOUT_TICKS(EXCH_TIMEOUT_TICKS)
  ) u_watchdog (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(joined),
    .activity_i(in_accept || out_accept),
    .tick_i(tick),
    .active_o(exch_active),
    .start_o(exch_start),
    .lost_o(exch_lost)
  );

  // Process data out

  // Status byte 3 built bit by bit from the shared layout
  wire [7:0] status_byte;
  assign status_byte[`SB_OUTPUT_FAULT_BIT] = output_fault_flag_i;
  assign status_byte[`SB_INPUT_FAULT_BIT] = input_fault_flag_i;
  assign status_byte[`SB_GENERAL_FAULT_BIT] = general_fault_flag_i;
  assign status_byte[`SB_DIAGNOSTIC_BIT] = diagnostic_flag_i;
  assign status_byte[`SB_RUN_BIT] = run_flag_i;
  // Exchange bit follows the watchdog, not raw traffic, so it does not flicker
  assign status_byte[`SB_EXCHANGE_BIT] = exch_active;
  assign status_byte[7:6] = 2'b00;

  wire [7:0] out_sel = out_byte(net_out_index_i, ext_mode, base_outputs_i, status_byte);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      net_out_data_o <= 8'h00;
      net_out_valid_o <= 1'b0;
    end else begin
      net_out_valid_o <= out_accept;
      if (out_accept) begin
        net_out_data_o <= out_sel;
      end
    end
  end

  assign network_state_indicator_o = exch_active;

  // Registered so the indicator driver never sees a decode glitch
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      module_state_indicator_o <= 1'b0;
    end else begin
      module_state_indicator_o <= joined;
    end
  end

  // Register bus slave

  logic ack;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic cfg_error_seen;

  // Full-word decode: a partial match never aliases a register
  function automatic logic reg_hit(input logic [5:0] addr, input logic [5:0] ofs);
    return addr == ofs;
  endfunction

  wire request = avs_read_i || avs_write_i;
  // Lane 0 holds every writable field
  wire wr_take = avs_write_i && ack && avs_byteenable_i[0];
  wire sel_ctrl = reg_hit(avs_address_i, `REG_CTRL_OFS);
  wire sel_nst = reg_hit(avs_address_i, `REG_NET_STATUS_OFS);
  wire sel_irq = reg_hit(avs_address_i, `REG_IRQ_STATUS_OFS);
  wire sel_mask = reg_hit(avs_address_i, `REG_IRQ_MASK_OFS);

  wire [31:0] net_status_word = (32'h0000_0000
    | (32'(rate_latched) << `NST_RATE_LSB)
    | (32'(cfg_error) << `NST_CFG_ERROR_BIT)
    | (32'(joined) << `NST_JOINED_BIT)
    | (32'(exch_active) << `NST_ACTIVE_BIT)
    | (32'(addr_latched) << `NST_ADDR_LSB));

  // Unmapped addresses read zero and ignore writes
  wire [31:0] read_mux = sel_ctrl ? 32'(ctrl)
                       : sel_nst ? net_status_word
                       : sel_irq ? 32'(irq_status)
                       : sel_mask ? 32'(irq_mask)
                       : 32'h0000_0000;

  // Fixed one wait state keeps the read mux off the bus path
  assign avs_waitrequest_o = request && !ack;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= request && !ack;
      if (avs_read_i && !ack) begin
        avs_readdata_o <= read_mux;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl <= `CTRL_RESET;
      irq_mask <= `IRQ_MASK_RESET;
    end else if (wr_take) begin
      if (sel_ctrl) begin
        ctrl <= avs_writedata_i[1:0];
      end
      if (sel_mask) begin
        irq_mask <= avs_writedata_i[3:0];
      end
    end
  end

  // Interrupts

  wire [3:0] irq_events;
  assign irq_events[`IRQ_EXCH_START_BIT] = exch_start;
  assign irq_events[`IRQ_EXCH_LOST_BIT] = exch_lost;
  assign irq_events[`IRQ_CFG_ERROR_BIT] = cfg_error && !cfg_error_seen;
  assign irq_events[`IRQ_RX_BYTE_BIT] = in_accept;

  // Write one to clear; zero bits leave their flag alone
  wire [3:0] irq_clear = (wr_take && sel_irq) ? avs_writedata_i[3:0] : 4'h0;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      irq_status <= `IRQ_RESET;
      cfg_error_seen <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
      cfg_error_seen <= cfg_error;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// ===== tb/io_mapper_assertions.sv
// Purpose: Port checks of the I/O image mapper.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into every mapper instance.
`timescale 1ns/100ps
`default_nettype none
module io_mapper_assertions #(
  parameter int IO_COUNT = 128
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic rate_switch_low_i,
  input wire logic rate_switch_high_i,
  input wire logic [5:0] addr_switch_i,
  input wire logic [1:0] bit_rate_select_o,
  input wire logic [5:0] station_address_o,
  input wire logic net_enable_o,
  input wire logic net_in_valid_i,
  input wire logic [4:0] net_in_index_i,
  input wire logic [7:0] net_in_data_i,
  input wire logic net_out_req_i,
  input wire logic [4:0] net_out_index_i,
  input wire logic [7:0] net_out_data_o,
  input wire logic net_out_valid_o,
  input wire logic [IO_COUNT-1:0] base_outputs_i,
  input wire logic [IO_COUNT-1:0] base_inputs_o,
  input wire logic output_fault_flag_i,
  input wire logic input_fault_flag_i,
  input wire logic general_fault_flag_i,
  input wire logic diagnostic_flag_i,
  input wire logic run_flag_i,
  input wire logic network_state_indicator_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [4:0] flags = {run_flag_i, diagnostic_flag_i, general_fault_flag_i, input_fault_flag_i,
                            output_fault_flag_i};
  wire logic out_ok = net_out_req_i && net_enable_o;
  wire logic both_on = rate_switch_low_i && rate_switch_high_i;
  sequence s_start;
    $rose(rst_n_i);
  endsequence
  sequence s_status;
    out_ok && net_out_index_i == 5'h03;
  endsequence
  // Only bytes left alone for a cycle, so no overwrite hides the result
  sequence s_in_hold;
    net_in_valid_i && net_enable_o && net_in_index_i < 5'h03 ##1 net_enable_o && !net_in_valid_i;
  endsequence
  a_out_answer: assert property (out_ok |=> net_out_valid_o) else $error("byte request unanswered");
  a_out_refused: assert property (!out_ok |=> !net_out_valid_o) else $error("answer without request");
  a_status_flags: assert property (s_status |=> net_out_data_o[4:0] == $past(flags))
    else $error("status flags wrong");
  a_exchange_bit: assert property (s_status |=> net_out_data_o[5] == $past(network_state_indicator_o))
    else $error("exchange bit wrong");
  a_status_spare: assert property (s_status |=> net_out_data_o[7:6] == 2'h0) else $error("spare bits set");
  a_first_byte: assert property (out_ok && net_out_index_i == 5'h00 |=>
    net_out_data_o == $past(base_outputs_i[7:0])) else $error("output byte 0 wrong");
  a_input_map: assert property (s_in_hold |=>
    base_inputs_o[$past(net_in_index_i, 2) * 8 +: 8] == $past(net_in_data_i, 2)) else $error("input byte wrong");
  a_rate_latch: assert property (s_start |=> bit_rate_select_o == $past({rate_switch_high_i, rate_switch_low_i}))
    else $error("rate not latched");
  a_addr_latch: assert property (s_start |=> station_address_o == $past(addr_switch_i))
    else $error("address not latched");
  a_auto_join: assert property ((s_start and !both_on) |=> net_enable_o) else $error("no join after reset");
  a_bad_rate: assert property ((s_start and both_on) |=> !net_enable_o [*4]) else $error("joined on bad rate");
endmodule
bind fieldbus_io_image_mapper io_mapper_assertions #(.IO_COUNT(IO_COUNT)) u_chk (.core_clk_i, .rst_n_i,
  .rate_switch_low_i, .rate_switch_high_i, .addr_switch_i, .bit_rate_select_o, .station_address_o, .net_enable_o,
  .net_in_valid_i, .net_in_index_i, .net_in_data_i, .net_out_req_i, .net_out_index_i, .net_out_data_o,
  .net_out_valid_o, .base_outputs_i, .base_inputs_o, .output_fault_flag_i, .input_fault_flag_i,
  .general_fault_flag_i, .diagnostic_flag_i, .run_flag_i, .network_state_indicator_o);
`default_nettype wire

// ===== tb/dnet_master_model.sv
// Purpose: Behavioural fieldbus master on the mapper's network ports.
// Assumes: Strobes launched just after a rising edge.
// Notes: Released lines carry inverted junk, never the last value.
`timescale 1ns/100ps
`default_nettype none
module dnet_master_model (
  input wire logic clk_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic tx_valid_o,
  output logic [4:0] tx_index_o,
  output logic [7:0] tx_data_o,
  output logic req_o,
  output logic [4:0] req_index_o
);
  initial begin
    tx_valid_o = 1'b0;
    tx_index_o = 5'h15;
    tx_data_o = 8'hA5;
    req_o = 1'b0;
    req_index_o = 5'h0A;
  end
  task automatic send_byte(input logic [4:0] idx, input logic [7:0] data);
    @(posedge clk_i);
    tx_valid_o <= 1'b1;
    tx_index_o <= idx;
    tx_data_o <= data;
    @(posedge clk_i);
    tx_valid_o <= 1'b0;
    tx_index_o <= ~idx;
    tx_data_o <= ~data;
  endtask
  // Answer stands one cycle only, so it is taken mid-cycle
  task automatic fetch_byte(input logic [4:0] idx, output logic ok, output logic [7:0] data);
    @(posedge clk_i);
    req_o <= 1'b1;
    req_index_o <= idx;
    @(posedge clk_i);
    req_o <= 1'b0;
    req_index_o <= ~idx;
    @(negedge clk_i);
    ok = rx_valid_i;
    data = rx_data_i;
  endtask
endmodule
`default_nettype wire

// ===== tb/test_fieldbus_io_image_mapper.sv
// Purpose: Self-checking bench of the fieldbus I/O image mapper.
// Assumes: Bus accesses wait on waitrequest, no fixed wait count.
// Notes: Short tick and timeout keep idle phases brief.
`timescale 1ns/100ps
`default_nettype none
module test_fieldbus_io_image_mapper;
  import io_mapper_pkg::*;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic rate_switch_low_i = 1'b0, rate_switch_high_i = 1'b0, run_flag_i = 1'b0, diagnostic_flag_i = 1'b0;
  logic output_fault_flag_i = 1'b0, input_fault_flag_i = 1'b0, general_fault_flag_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00, addr_switch_i = 6'h00, station_address_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [127:0] base_outputs_i = 128'h0, base_inputs_o;
  logic [1:0] bit_rate_select_o;
  logic avs_waitrequest_o, irq_o, net_enable_o, net_in_valid_i, net_out_req_i, net_out_valid_o, ok;
  logic network_state_indicator_o, module_state_indicator_o;
  logic [4:0] net_in_index_i, net_out_index_i;
  logic [7:0] net_in_data_i, net_out_data_o, d;
  logic [7:0] img [$];
  int seed = 32'h1ACB47C1, mismatches = 0, total_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  fieldbus_io_image_mapper #(.TICK_CYCLES(4), .EXCH_TIMEOUT_TICKS(2)) DUT (.core_clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o, .irq_o, .rate_switch_low_i, .rate_switch_high_i, .addr_switch_i, .bit_rate_select_o,
    .station_address_o, .net_enable_o, .net_in_valid_i, .net_in_index_i, .net_in_data_i, .net_out_req_i,
    .net_out_index_i, .net_out_data_o, .net_out_valid_o, .base_outputs_i, .base_inputs_o, .output_fault_flag_i,
    .input_fault_flag_i, .general_fault_flag_i, .diagnostic_flag_i, .run_flag_i, .network_state_indicator_o,
    .module_state_indicator_o);
  dnet_master_model master (.clk_i(core_clk_i), .rx_data_i(net_out_data_o), .rx_valid_i(net_out_valid_o),
    .tx_valid_o(net_in_valid_i), .tx_index_o(net_in_index_i), .tx_data_o(net_in_data_i), .req_o(net_out_req_i),
    .req_index_o(net_out_index_i));
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_write_i <= we;
    avs_read_i <= !we;
    avs_writedata_i <= wd;
    // Request stands until waitrequest is seen low at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge core_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic restart(input logic [1:0] sw, input logic [5:0] a);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    {rate_switch_high_i, rate_switch_low_i} <= sw;
    addr_switch_i <= a;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  function automatic logic [7:0] exp_out(int k, bit ext, bit exch);
    if (k < 3) return base_outputs_i[8*k +: 8];
    if (k == 3) return {2'h0, exch, run_flag_i, diagnostic_flag_i, general_fault_flag_i, input_fault_flag_i,
      output_fault_flag_i};
    if (ext && k <= 16) return base_outputs_i[8*(k-1) +: 8];
    return 8'h00;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      d = 8'(i == 2 ? $random(seed) : 63 - 21 * i);
      restart(2'(3 - i), d[5:0]);
      chk(bit_rate_select_o, i == 0 ? RATE_BAD : i == 1 ? RATE_500K : i == 2 ? RATE_250K : RATE_125K);
      chk(station_address_o, d[5:0]);
      chk(net_enable_o, i != 0);
      chk(module_state_indicator_o, i != 0);
    end
    $display("test startup done");
    @(posedge core_clk_i);
    base_outputs_i <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    q = $random(seed);
    {run_flag_i, diagnostic_flag_i, general_fault_flag_i, input_fault_flag_i, output_fault_flag_i} <= q[4:0];
    for (int k = 0; k < 5; k++) begin
      master.fetch_byte(5'(k), ok, d);
      chk({ok, d}, {1'b1, exp_out(k, 1'b0, 1'b1)});
    end
    chk(network_state_indicator_o, 1'b1);
    repeat (40) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(network_state_indicator_o, 1'b0);
    master.fetch_byte(5'h03, ok, d);
    chk(d, exp_out(3, 1'b0, 1'b0));
    $display("test outputs done");
    for (int k = 0; k < 4; k++) begin
      img.push_back(k < 3 ? 8'($random(seed)) : 8'h00);
      master.send_byte(5'(k), k < 3 ? img[k] : 8'hFF);
    end
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(base_inputs_o[31:0], {img[3], img[2], img[1], img[0]});
    $display("test inputs done");
    bus(1'b1, 6'h08, 32'hF);
    bus(1'b1, 6'h0C, 32'h8);
    chk(irq_o, 1'b0);
    bus(1'b1, 6'h00, 32'h3);
    d = 8'($random(seed));
    master.send_byte(5'h0F, d);
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(base_inputs_o[127:120], d);
    chk(irq_o, 1'b1);
    bus(1'b1, 6'h08, 32'h8);
    chk(irq_o, 1'b0);
    master.fetch_byte(5'h10, ok, d);
    chk(d, exp_out(16, 1'b1, 1'b0));
    bus(1'b0, 6'h04, 32'h0);
    chk({q[13:8], q[3]}, 7'h01);
    bus(1'b0, 6'h14, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 6'h00, 32'h1);
    master.fetch_byte(5'h00, ok, d);
    chk({ok, net_enable_o, module_state_indicator_o}, 3'h0);
    chk(base_inputs_o, 128'h0);
    $display("test registers done");
    report_and_stop();
  end
endmodule
`default_nettype wire
